// ### src/vle_pkg.sv
// constants shared by the variable-length encoder and its coefficient queue
// assumes a single core clock and a processor-side register port
`default_nettype none
package vle_pkg;
    // ----------------------------------------
    // register map (byte offsets)
    // ----------------------------------------
    localparam logic [11:0] OFS_CODED_BIT_COUNT = 12'h6d0;  // read-only bit count
    localparam logic [11:0] OFS_COEFF_CODE_RES = 12'h6d4;   // read-only coefficient code
    localparam logic [11:0] OFS_ENC_CODE_RES = 12'h6d8;     // read-only command result
    localparam logic [11:0] OFS_ENC_COMMAND = 12'h6dc;      // write-only command

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int CNT_W = 16;            // bit count field width
    localparam int OVF_BIT = 16;          // overflow flag in the bit count register
    localparam int CMD_DATA_W = 16;       // command symbol width
    localparam int CMD_TABLE_LSB = 16;    // table indicator position
    localparam int CMD_TABLE_W = 2;       // table indicator width
    localparam int RES_LEN_LSB = 24;      // code length position in results
    localparam int RES_CODE_W = 24;       // code value width in results
    localparam int RL_RUN_W = 6;          // run field width
    localparam int RL_LEVEL_W = 12;       // signed level field width
    localparam int RL_LAST_BIT = 31;      // last-of-picture flag in a queue entry

    // ----------------------------------------
    // counts and reset values
    // ----------------------------------------
    localparam int QUEUE_DEPTH = 16;      // queue entries
    localparam int QUEUE_WIDTH = 32;      // bits per entry
    localparam logic [CNT_W-1:0] OVERFLOW_BITS = 16'h0200;  // counts above this overflow
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;     // results after reset
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;      // zero reads as busy

    // ----------------------------------------
    // symbol tables for commands
    // ----------------------------------------
    typedef enum logic [1:0] {
        TBL_FIXED8 = 2'h0,
        TBL_FIXED16 = 2'h1,
        TBL_COMPACT = 2'h2,
        TBL_NONE = 2'h3
    } table_e;

    // coding sequencer, gray along idle -> code -> finish
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CODE = 2'h1,
        ST_FINISH = 2'h3
    } enc_state_e;
endpackage
`default_nettype wire

// ### src/queue_if.sv
// push and pop sides of the coefficient queue
// assumes both ends run on the same clock
`default_nettype none
interface queue_if #(parameter int WIDTH = 32);
    logic in_valid;               // producer offers a word
    logic in_ready;               // queue has room
    logic [WIDTH-1:0] in_data;    // word offered
    logic out_valid;              // queue holds a word
    logic out_ready;              // consumer takes it
    logic [WIDTH-1:0] out_data;   // oldest word
    modport queue (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ### src/coeff_queue.sv
// first-in first-out queue of flip-flops with registered flags
// assumes one clock; flags are flops so the top can pass them out directly
`default_nettype none
module coeff_queue #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    queue_if.queue q
);
    localparam int AW = $clog2(DEPTH);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("queue depth must be a power of two of at least 2");
        end
    endgenerate

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    logic [WIDTH-1:0] mem_q [DEPTH];   // entries
    logic [AW-1:0] wr_q;               // write index
    logic [AW-1:0] rd_q;               // read index
    logic [AW:0] cnt_q;                // fill level
    logic not_full_q;                  // registered ready
    logic not_empty_q;                 // registered valid

    wire push = q.in_valid && not_full_q;
    wire pop = q.out_ready && not_empty_q;
    wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    assign q.in_ready = not_full_q;
    assign q.out_valid = not_empty_q;
    assign q.out_data = mem_q[rd_q];

    // pointers, level and flags
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            not_full_q <= 1'b1;
            not_empty_q <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            not_full_q <= cnt_d != (AW+1)'(DEPTH);
            not_empty_q <= cnt_d != '0;
        end
    end

    // data written only, no reset needed
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_q] <= q.in_data;
        end
    end
endmodule
`default_nettype wire

// ### src/variable_length_encoder.sv
// variable-length encoder: run-level coding from a queue plus command coding
// assumes the processor and transform stage share mclk_i; no synchronisers needed
// Function
// - push each run-level pair into 16x32 queue
// - report generated bits; above 512 is overflow
// - bit count zero means still busy
// - interrupt when coded length exceeds queue threshold
// - command write codes symbol from chosen table
`default_nettype none
module variable_length_encoder #(
    parameter int DEPTH = vle_pkg::QUEUE_DEPTH,
    parameter int WIDTH = vle_pkg::QUEUE_WIDTH
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic rl_valid_i,                               // run-level pair offered
    input wire logic [vle_pkg::RL_RUN_W-1:0] rl_run_i,         // zero run
    input wire logic [vle_pkg::RL_LEVEL_W-1:0] rl_level_i,     // signed level
    input wire logic rl_last_i,                                // last pair of the picture
    output logic rl_ready_o,                                   // queue has room
    input wire logic run_level_trigger_i,                      // start coding pulse
    input wire logic [11:0] reg_addr_i,                        // register byte offset
    input wire logic reg_rd_i,                                 // read strobe
    input wire logic reg_wr_i,                                 // write strobe
    input wire logic [31:0] reg_wdata_i,                       // write data
    output logic [31:0] reg_rdata_o,                           // read data, next cycle
    output logic code_length_irq_o                             // coded length past threshold
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    generate
        if (WIDTH != 32) begin : g_bad_width
            $error("queue entries must be 32 bits");
        end
    endgenerate

    // ----------------------------------------
    // code helpers
    // ----------------------------------------
    // length of a run-level code: short form or 24-bit escape
    function automatic logic [7:0] rl_len(input logic [vle_pkg::RL_RUN_W-1:0] run,
                                          input logic [vle_pkg::RL_LEVEL_W-1:0] lvl);
        logic [vle_pkg::RL_LEVEL_W-1:0] mag;
        mag = lvl[vle_pkg::RL_LEVEL_W-1] ? -lvl : lvl;
        if (run < 6'h10 && mag < 12'h010) begin
            rl_len = 8'h0a;       // 1 flag + 4 run + 4 magnitude + 1 sign
        end else begin
            rl_len = 8'h18;       // escape: 6 marker bits + 6 run + 12 level
        end
    endfunction

    // code bits of a run-level pair, right aligned
    function automatic logic [23:0] rl_code(input logic [vle_pkg::RL_RUN_W-1:0] run,
                                            input logic [vle_pkg::RL_LEVEL_W-1:0] lvl);
        logic [vle_pkg::RL_LEVEL_W-1:0] mag;
        mag = lvl[vle_pkg::RL_LEVEL_W-1] ? -lvl : lvl;
        if (run < 6'h10 && mag < 12'h010) begin
            rl_code = {14'h0000, 1'b1, run[3:0], mag[3:0], lvl[vle_pkg::RL_LEVEL_W-1]};
        end else begin
            rl_code = {6'h01, run, lvl};
        end
    endfunction

    // number of significant bits of a symbol, at least one
    function automatic logic [7:0] sig_bits(input logic [15:0] v);
        sig_bits = 8'h01;
        for (int i = 1; i < 16; i++) begin
            if (v[i]) begin
                sig_bits = 8'(i + 1);
            end
        end
    endfunction

    // ----------------------------------------
    // queue
    // ----------------------------------------
    queue_if #(.WIDTH(WIDTH)) qi ();

    coeff_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_queue (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .q(qi.queue)
    );

    localparam logic [15:0] THRESHOLD_BITS = 16'(DEPTH * WIDTH);  // bits the queue can hold

    // pack the pair into one entry
    assign qi.in_valid = rl_valid_i;
    assign qi.in_data = {rl_last_i, 13'h0000, rl_run_i, rl_level_i};
    assign rl_ready_o = qi.in_ready;   // registered flag inside the queue

    // ----------------------------------------
    // coding sequencer
    // ----------------------------------------
    vle_pkg::enc_state_e state_q;                 // sequencer state
    logic [vle_pkg::CNT_W-1:0] total_q;           // bits coded so far
    logic [vle_pkg::CNT_W-1:0] count_q;           // published count, zero while busy
    logic ovf_q;                                  // published overflow flag
    logic [31:0] coeff_res_q;                     // trailing 32 coded bits
    logic irq_q;                                  // interrupt level

    wire [WIDTH-1:0] head = qi.out_data;
    wire [vle_pkg::RL_RUN_W-1:0] head_run = head[vle_pkg::RL_LEVEL_W +: vle_pkg::RL_RUN_W];
    wire [vle_pkg::RL_LEVEL_W-1:0] head_lvl = head[vle_pkg::RL_LEVEL_W-1:0];
    wire head_last = head[vle_pkg::RL_LAST_BIT];
    wire coding = state_q == vle_pkg::ST_CODE;
    wire take = coding && qi.out_valid;
    wire [7:0] take_len = rl_len(head_run, head_lvl);
    wire [vle_pkg::CNT_W-1:0] total_d = total_q + vle_pkg::CNT_W'(take_len);
    wire start = run_level_trigger_i && state_q == vle_pkg::ST_IDLE;

    assign qi.out_ready = coding;

    // sequencer: idle until triggered, code up to the last pair, then publish
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= vle_pkg::ST_IDLE;
        end else begin
            case (state_q)
                vle_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= vle_pkg::ST_CODE;
                    end
                end
                vle_pkg::ST_CODE: begin
                    if (take && head_last) begin
                        state_q <= vle_pkg::ST_FINISH;
                    end
                end
                vle_pkg::ST_FINISH: begin
                    state_q <= vle_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= vle_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // running total and trailing code bits
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            total_q <= vle_pkg::COUNT_RST;
            coeff_res_q <= vle_pkg::RESULT_RST;
        end else if (start) begin
            total_q <= vle_pkg::COUNT_RST;
            coeff_res_q <= vle_pkg::RESULT_RST;
        end else if (take) begin
            total_q <= total_d;
            coeff_res_q <= (coeff_res_q << take_len) | {8'h00, rl_code(head_run, head_lvl)};
        end
    end

    // published count: zero from trigger until the last pair is coded
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_q <= vle_pkg::COUNT_RST;
            ovf_q <= 1'b0;
        end else if (start) begin
            count_q <= vle_pkg::COUNT_RST;
            ovf_q <= 1'b0;
        end else if (state_q == vle_pkg::ST_FINISH) begin
            count_q <= total_q;
            ovf_q <= total_q > vle_pkg::OVERFLOW_BITS;
        end
    end

    // interrupt level: set past the queue threshold, cleared on next trigger
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_q <= 1'b0;
        end else if (take && total_d > THRESHOLD_BITS) begin
            irq_q <= 1'b1;
        end else if (start) begin
            irq_q <= 1'b0;
        end
    end

    assign code_length_irq_o = irq_q;

    // ----------------------------------------
    // command coding
    // ----------------------------------------
    logic [31:0] enc_res_q;                   // last command result
    wire cmd_wr = reg_wr_i && reg_addr_i == vle_pkg::OFS_ENC_COMMAND;
    wire [15:0] cmd_sym = reg_wdata_i[vle_pkg::CMD_DATA_W-1:0];
    wire [1:0] cmd_tbl = reg_wdata_i[vle_pkg::CMD_TABLE_LSB +: vle_pkg::CMD_TABLE_W];
    wire [7:0] cmp_len = sig_bits(cmd_sym);
    logic [7:0] cmd_len;
    logic [23:0] cmd_code;

    // table select: fixed 8, fixed 16, shortest binary, or no code
    always_comb begin
        case (vle_pkg::table_e'(cmd_tbl))
            vle_pkg::TBL_FIXED8: begin
                cmd_len = 8'h08;
                cmd_code = {16'h0000, cmd_sym[7:0]};
            end
            vle_pkg::TBL_FIXED16: begin
                cmd_len = 8'h10;
                cmd_code = {8'h00, cmd_sym};
            end
            vle_pkg::TBL_COMPACT: begin
                cmd_len = cmp_len;
                cmd_code = {8'h00, cmd_sym};
            end
            default: begin
                cmd_len = 8'h00;
                cmd_code = 24'h000000;
            end
        endcase
    end

    // result register follows every command write
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            enc_res_q <= vle_pkg::RESULT_RST;
        end else if (cmd_wr) begin
            enc_res_q <= {cmd_len, cmd_code};
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    wire [31:0] count_word = {15'h0000, ovf_q, count_q};
    logic [31:0] rd_mux;

    // decode; command register and unmapped offsets read zero
    always_comb begin
        case (reg_addr_i)
            vle_pkg::OFS_CODED_BIT_COUNT: rd_mux = count_word;
            vle_pkg::OFS_COEFF_CODE_RES: rd_mux = coeff_res_q;
            vle_pkg::OFS_ENC_CODE_RES: rd_mux = enc_res_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered, held until the next read
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end
endmodule
`default_nettype wire

// ### tb/vle_monitor.sv
// assertions on the encoder top ports
// assumes a bind from the bench; one clock domain
`default_nettype none
module vle_monitor #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic rl_valid_i,
    input wire logic [vle_pkg::RL_RUN_W-1:0] rl_run_i,
    input wire logic [vle_pkg::RL_LEVEL_W-1:0] rl_level_i,
    input wire logic rl_last_i,
    input wire logic rl_ready_o,
    input wire logic run_level_trigger_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic code_length_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // decoded accesses
    // ----------------------------------------
    wire logic rd_cnt = reg_rd_i && (reg_addr_i == vle_pkg::OFS_CODED_BIT_COUNT);  // count read
    wire logic rd_res = reg_rd_i && (reg_addr_i == vle_pkg::OFS_ENC_CODE_RES);     // result read
    wire logic rd_cmd = reg_rd_i && (reg_addr_i == vle_pkg::OFS_ENC_COMMAND);      // command read
    wire logic wr_cmd = reg_wr_i && (reg_addr_i == vle_pkg::OFS_ENC_COMMAND);      // command write

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_reset_quiet: assert property (disable iff (1'b0) !nrst_i |-> rl_ready_o && !code_length_irq_o)
        else $error("outputs not quiet in reset");
    chk_cmd_reads_zero: assert property (rd_cmd |=> reg_rdata_o == 32'h0)
        else $error("command register read not zero");
    chk_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    chk_full_on_push: assert property ($fell(rl_ready_o) |-> $past(rl_valid_i))
        else $error("queue went full without a push");
    chk_count_format: assert property (rd_cnt |=> reg_rdata_o[31:17] == 15'h0 &&
        reg_rdata_o[16] == (reg_rdata_o[15:0] > DEPTH * WIDTH))
        else $error("bit count overflow flag wrong");
    chk_ovf_has_irq: assert property (rd_cnt && !run_level_trigger_i ##1 reg_rdata_o[16] |-> code_length_irq_o)
        else $error("overflow without interrupt");
    chk_fixed8_code: assert property (wr_cmd && reg_wdata_i[17:16] == 2'h0 ##1 !reg_wr_i ##1 rd_res |=>
        reg_rdata_o == {8'h08, 16'h0, $past(reg_wdata_i[7:0], 3)})
        else $error("fixed 8 result wrong");
    chk_fixed16_code: assert property (wr_cmd && reg_wdata_i[17:16] == 2'h1 ##1 !reg_wr_i ##1 rd_res |=>
        reg_rdata_o == {8'h10, 8'h0, $past(reg_wdata_i[15:0], 3)})
        else $error("fixed 16 result wrong");
endmodule
`default_nettype wire

// ### tb/rl_source.sv
// stand-in for the transform stage feeding run-level pairs
// assumes the bench queues pairs through send(); one clock
`default_nettype none
module rl_source (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic slow_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [vle_pkg::RL_RUN_W-1:0] run_o,
    output logic [vle_pkg::RL_LEVEL_W-1:0] level_o,
    output logic last_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [18:0] pend_q[$];  // {last, run, level} still to send

    // add one pair to the send list
    task automatic send(input logic [18:0] p);
        pend_q.push_back(p);
    endtask

    // offer the head and hold it until taken; scramble lines while idle
    initial begin
        valid_o = 1'b0;
        {last_o, run_o, level_o} = 19'h0;
        forever begin
            @(posedge mclk_i);
            if (valid_o && ready_i) begin  // pair taken at this edge
                void'(pend_q.pop_front());
            end
            if (pend_q.size() > 0 && nrst_i && ((valid_o && !ready_i) || !slow_i || $urandom_range(3) == 0)) begin
                valid_o <= 1'b1;  // refused offers are held unchanged
                {last_o, run_o, level_o} <= pend_q[0];
            end else begin
                valid_o <= 1'b0;
                {last_o, run_o, level_o} <= ~{last_o, run_o, level_o};
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/variable_length_encoder_tb.sv
// self-checking bench for the variable-length encoder
// assumes package, interface, queue and encoder compile first
`default_nettype none
module variable_length_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // reset starts high so that its drop just after time zero is a real falling edge
    logic mclk = 1'b0, nrst = 1'b1, slow = 1'b0, trig = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
    logic rl_valid, rl_last, rl_ready, irq;
    logic [5:0] rl_run;
    logic [11:0] rl_level;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    int err_total = 0, checks_done = 0;

    // ----------------------------------------
    // clock, parts and watchdog
    // ----------------------------------------
    initial forever #12.5 mclk = ~mclk;
    rl_source src (.mclk_i(mclk), .nrst_i(nrst), .slow_i(slow), .ready_i(rl_ready), .valid_o(rl_valid),
        .run_o(rl_run), .level_o(rl_level), .last_o(rl_last));
    variable_length_encoder dut (.mclk_i(mclk), .nrst_i(nrst), .rl_valid_i(rl_valid), .rl_run_i(rl_run),
        .rl_level_i(rl_level), .rl_last_i(rl_last), .rl_ready_o(rl_ready), .run_level_trigger_i(trig),
        .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .code_length_irq_o(irq));
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        end_of_test();
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_read(input logic [11:0] a, output logic [31:0] v);
        @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk) reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk) reg_wr <= 1'b0;
    endtask
    task automatic trigger();
        @(posedge mclk) trig <= 1'b1;
        @(posedge mclk) trig <= 1'b0;
    endtask
    task automatic wait_count(output logic [31:0] v);
        v = 32'h0;
        for (int i = 0; i < 300 && v === 32'h0; i++) reg_read(vle_pkg::OFS_CODED_BIT_COUNT, v);
    endtask
    function automatic logic [31:0] cmd_exp(input logic [1:0] t, input logic [15:0] d);
        logic [7:0] n;
        n = 8'h1;
        for (int b = 0; b < 16; b++) if (d[b]) n = 8'(b + 1);
        case (t)
            2'h0: return {8'h08, 16'h0, d[7:0]};
            2'h1: return {8'h10, 8'h0, d};
            2'h2: return {n, 8'h0, d};
            default: return 32'h0;
        endcase
    endfunction
    function automatic int pair_len(input logic [5:0] r, input logic [11:0] l);
        logic [11:0] m;
        m = l[11] ? (~l + 12'h1) : l;
        return (r < 6'h10 && m < 12'h010) ? 10 : 24;
    endfunction
    // code of a pair: flag, run, magnitude, sign; or escape marker, run, level
    function automatic logic [23:0] pair_code(input logic [5:0] r, input logic [11:0] l);
        logic [11:0] m;
        m = l[11] ? (~l + 12'h1) : l;
        if (pair_len(r, l) == 10) return {14'h0, 1'b1, r[3:0], m[3:0], l[11]};
        return {6'h01, r, l};
    endfunction
    // queue a picture past full, then code it and check count and interrupt
    task automatic code_picture(input int n, input bit long_only);
        logic [31:0] v;
        logic [5:0] r;
        logic [11:0] l;
        int total;
        logic [31:0] res;
        total = 0;
        res = 32'h0;
        for (int i = 0; i < n; i++) begin
            r = long_only ? 6'h3f : 6'($urandom_range(20));
            l = 12'($urandom_range(40)) - 12'h014;
            total += pair_len(r, l);
            res = (res << pair_len(r, l)) | {8'h00, pair_code(r, l)};
            src.send({i == n - 1, r, l});
        end
        for (int i = 0; i < 200 && rl_ready !== 1'b0; i++) @(posedge mclk);
        #1;
        check("ready_full", {31'h0, rl_ready}, 32'h0);
        check("held_offer", {31'h0, rl_valid}, 32'h1);
        slow = long_only;
        trigger();
        reg_read(vle_pkg::OFS_CODED_BIT_COUNT, v);
        check("busy_count", v, 32'h0);
        wait_count(v);
        check("bit_count", v, {15'h0, total > 512, 16'(total)});
        reg_read(vle_pkg::OFS_COEFF_CODE_RES, v);
        check("coeff_result", v, res);
        check("irq", {31'h0, irq}, {31'h0, total > 512});
        $display("test picture of %0d pairs done", n);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] v;
        logic [15:0] d;
        logic [11:0] addrs [5];
        addrs = '{12'h6d0, 12'h6d4, 12'h6d8, 12'h6dc, 12'h6e0};
        void'($urandom(81));
        #1 nrst = 1'b0;  // falling edge resets every flop except the queue storage before the first clock edge
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        reg_write(vle_pkg::OFS_CODED_BIT_COUNT, 32'hffff_ffff);
        foreach (addrs[k]) begin
            reg_read(addrs[k], v);
            check("reset_value", v, 32'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            d = (i < 4) ? 16'($urandom) : {16{i[0]}};  // corners: zero in tables 0 and 2, all ones in tables 1 and 3
            reg_write(vle_pkg::OFS_ENC_COMMAND, {14'h0, 2'(i), d});
            reg_read(vle_pkg::OFS_ENC_CODE_RES, v);
            check("cmd_result", v, cmd_exp(2'(i), d));
        end
        $display("test commands done");
        code_picture(17, 1'b0);
        code_picture(22, 1'b1);
        trigger();
        #1;
        check("irq_cleared", {31'h0, irq}, 32'h0);
        src.send({1'b1, 6'h0f, 12'hff1});
        wait_count(v);
        check("short_pair", v, 32'h0000_000a);
        reg_read(vle_pkg::OFS_COEFF_CODE_RES, v);
        check("short_code", v, 32'h0000_03ff);
        $display("test late pair done");
        end_of_test();
    end
endmodule

bind variable_length_encoder vle_monitor #(.DEPTH(DEPTH), .WIDTH(WIDTH)) mon (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .rl_valid_i(rl_valid_i), .rl_run_i(rl_run_i), .rl_level_i(rl_level_i), .rl_last_i(rl_last_i),
    .rl_ready_o(rl_ready_o), .run_level_trigger_i(run_level_trigger_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .code_length_irq_o(code_length_irq_o));
`default_nettype wire
